// ===== verilog/logic_cell_pkg.sv
// Constants and types shared by the logic cell storage and RAM block.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package logic_cell_pkg;

  // Register byte offsets.
  localparam logic [11:0] STORE_CFG_OFFSET  = 12'h000;
  localparam logic [11:0] RAM_CFG_OFFSET    = 12'h004;
  localparam logic [11:0] INIT_CTRL_OFFSET  = 12'h008;
  localparam logic [11:0] CELL_STAT_OFFSET  = 12'h00C;

  // Storage configuration field positions.
  localparam int LATCH_MODE_BIT  = 0;
  localparam int CLK_INV_LSB     = 1;
  localparam int CE_PERM_LSB     = 3;
  localparam int SR_VALUE_LSB    = 5;
  localparam int SR_CONN_LSB     = 7;
  localparam int SRC0_LSB        = 9;
  localparam int SRC1_LSB        = 11;
  localparam int STORE_CFG_WIDTH = 13;

  // RAM configuration field positions.
  localparam int RAM_MODE_LSB    = 0;
  localparam int WCLK_INV_BIT    = 2;
  localparam int H_TABLE_LSB     = 4;
  localparam int RAM_CFG_WIDTH   = 12;

  // Control bit that fires the global init pulse.
  localparam int INIT_PULSE_BIT  = 0;

  // Reset values: flops reset to zero, enables connected, no RAM.
  localparam logic [STORE_CFG_WIDTH-1:0] STORE_CFG_RESET = 13'h0000;
  localparam logic [RAM_CFG_WIDTH-1:0]   RAM_CFG_RESET   = 12'h000;

  typedef enum logic [1:0] {
    RAM_OFF,
    RAM_16X2,
    RAM_16X1,
    RAM_32X1
  } ram_mode_type;

  typedef enum logic [1:0] {
    SRC_F,
    SRC_G,
    SRC_H,
    SRC_D0
  } store_src_type;

  typedef struct packed {
    logic       cell_clock;
    logic       storage_clock_enable;
    logic       set_reset_input;
    logic       write_enable;
    logic       direct_in_zero;
    logic       direct_in_one;
    logic [3:0] first_lut_inputs;
    logic [3:0] second_lut_inputs;
  } cell_in_type;

  typedef struct packed {
    logic [1:0] store_q;
    logic       f_out;
    logic       g_out;
    logic       h_out;
    logic       ram_read_out;
  } cell_out_type;

endpackage

// ===== verilog/logic_cell.sv
// Storage elements and distributed RAM of one logic cell, configured over APB.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module logic_cell (
  input  wire  logic                         pclk,
  input  wire  logic                         presetn,
  input  wire  logic [11:0]                  paddr,
  input  wire  logic                         psel,
  input  wire  logic                         penable,
  input  wire  logic                         pwrite,
  input  wire  logic [31:0]                  pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire  logic_cell_pkg::cell_in_type  cell_in,
  output logic_cell_pkg::cell_out_type       cell_out
);

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  logic [logic_cell_pkg::STORE_CFG_WIDTH-1:0] store_cfg_q, store_cfg_d;
  logic [logic_cell_pkg::RAM_CFG_WIDTH-1:0]   ram_cfg_q, ram_cfg_d;
  logic                                       init_pulse_q, init_pulse_d;
  logic [31:0]                                prdata_q, prdata_d;
  logic                                       clk_pin_q, clk_pin_d;
  logic [1:0]                                 store_q, store_d;
  logic [15:0]                                mem_f_q, mem_f_d;
  logic [15:0]                                mem_g_q, mem_g_d;

  logic                                       setup_phase;
  logic                                       wr_access;
  logic                                       addr_hit;
  logic                                       rise_edge;
  logic                                       fall_edge;
  logic                                       wclk_edge;
  logic                                       write_pulse;
  logic [3:0]                                 g_addr;
  logic                                       f_out;
  logic                                       g_out;
  logic                                       h_out;
  logic                                       ram_read_out;
  logic [3:0]                                 store_src;
  logic_cell_pkg::ram_mode_type               ram_mode;

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  function automatic logic known_offset(input logic [11:0] addr);
    known_offset = (addr == logic_cell_pkg::STORE_CFG_OFFSET) ||
                   (addr == logic_cell_pkg::RAM_CFG_OFFSET)   ||
                   (addr == logic_cell_pkg::INIT_CTRL_OFFSET) ||
                   (addr == logic_cell_pkg::CELL_STAT_OFFSET);
  endfunction

  function automatic logic pick_source(input logic [1:0] sel, input logic f,
                                       input logic g, input logic h, input logic d0);
    case (logic_cell_pkg::store_src_type'(sel))
      logic_cell_pkg::SRC_F:  pick_source = f;
      logic_cell_pkg::SRC_G:  pick_source = g;
      logic_cell_pkg::SRC_H:  pick_source = h;
      logic_cell_pkg::SRC_D0: pick_source = d0;
      default:                pick_source = d0;
    endcase
  endfunction

  //----------------------------------------------------------------------------
  // APB slave
  //----------------------------------------------------------------------------
  // Zero wait states; read data is sampled in the setup cycle so it comes from a flop.
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & addr_hit;
  assign addr_hit    = known_offset(paddr);
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~addr_hit;
  assign prdata      = prdata_q;

  always_comb begin
    store_cfg_d  = store_cfg_q;
    ram_cfg_d    = ram_cfg_q;
    init_pulse_d = 1'b0;
    prdata_d     = prdata_q;
    if (wr_access && paddr == logic_cell_pkg::STORE_CFG_OFFSET) begin
      store_cfg_d = pwdata[logic_cell_pkg::STORE_CFG_WIDTH-1:0];
    end
    if (wr_access && paddr == logic_cell_pkg::RAM_CFG_OFFSET) begin
      ram_cfg_d = pwdata[logic_cell_pkg::RAM_CFG_WIDTH-1:0];
    end
    if (wr_access && paddr == logic_cell_pkg::INIT_CTRL_OFFSET) begin
      init_pulse_d = pwdata[logic_cell_pkg::INIT_PULSE_BIT];
    end
    if (setup_phase) begin
      case (paddr)
        logic_cell_pkg::STORE_CFG_OFFSET: prdata_d = {19'h00000, store_cfg_q};
        logic_cell_pkg::RAM_CFG_OFFSET:   prdata_d = {20'h00000, ram_cfg_q};
        logic_cell_pkg::CELL_STAT_OFFSET: begin
          prdata_d = {26'h0000000, store_q, f_out, g_out, h_out, ram_read_out};
        end
        default:                          prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_cfg_q  <= logic_cell_pkg::STORE_CFG_RESET;
      ram_cfg_q    <= logic_cell_pkg::RAM_CFG_RESET;
      init_pulse_q <= 1'b0;
      prdata_q     <= 32'h00000000;
    end else begin
      store_cfg_q  <= store_cfg_d;
      ram_cfg_q    <= ram_cfg_d;
      init_pulse_q <= init_pulse_d;
      prdata_q     <= prdata_d;
    end
  end

  //----------------------------------------------------------------------------
  // Cell clock edges
  //----------------------------------------------------------------------------
  // The cell clock pin is compared with its level at the previous pclk, so an edge is seen at the first pclk after it.
  assign clk_pin_d = cell_in.cell_clock;
  assign rise_edge = cell_in.cell_clock & ~clk_pin_q;
  assign fall_edge = ~cell_in.cell_clock & clk_pin_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_pin_q <= 1'b0;
    end else begin
      clk_pin_q <= clk_pin_d;
    end
  end

  //----------------------------------------------------------------------------
  // Distributed RAM
  //----------------------------------------------------------------------------
  assign ram_mode  = logic_cell_pkg::ram_mode_type'(
                       ram_cfg_q[logic_cell_pkg::RAM_MODE_LSB +: 2]);
  assign wclk_edge = ram_cfg_q[logic_cell_pkg::WCLK_INV_BIT] ?
                     fall_edge : rise_edge;
  assign write_pulse = wclk_edge & cell_in.write_enable;
  assign g_addr    = (ram_mode == logic_cell_pkg::RAM_32X1) ?
                     cell_in.first_lut_inputs : cell_in.second_lut_inputs;

  // Both tables always act as lookup logic; only RAM modes make them writable.
  assign f_out = mem_f_q[cell_in.first_lut_inputs];
  assign g_out = mem_g_q[g_addr];
  assign ram_read_out = (ram_mode == logic_cell_pkg::RAM_32X1 && cell_in.direct_in_one) ?
                        g_out : f_out;
  assign h_out = (ram_mode == logic_cell_pkg::RAM_32X1) ? ram_read_out :
                 ram_cfg_q[logic_cell_pkg::H_TABLE_LSB +
                           {cell_in.direct_in_one, g_out, f_out}];

  always_comb begin
    mem_f_d = mem_f_q;
    mem_g_d = mem_g_q;
    if (write_pulse) begin
      case (ram_mode)
        logic_cell_pkg::RAM_16X2: begin
          mem_f_d[cell_in.first_lut_inputs]  = cell_in.direct_in_zero;
          mem_g_d[cell_in.second_lut_inputs] = cell_in.direct_in_one;
        end
        logic_cell_pkg::RAM_16X1: begin
          mem_f_d[cell_in.first_lut_inputs] = cell_in.direct_in_zero;
        end
        logic_cell_pkg::RAM_32X1: begin
          if (cell_in.direct_in_one) begin
            mem_g_d[cell_in.first_lut_inputs] = cell_in.direct_in_zero;
          end else begin
            mem_f_d[cell_in.first_lut_inputs] = cell_in.direct_in_zero;
          end
        end
        default: begin
          mem_f_d = mem_f_q;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_f_q <= 16'h0000;
      mem_g_q <= 16'h0000;
    end else begin
      mem_f_q <= mem_f_d;
      mem_g_q <= mem_g_d;
    end
  end

  //----------------------------------------------------------------------------
  // Storage elements
  //----------------------------------------------------------------------------
  // Sources read the RAM outputs before the write lands, so a flop on the same
  // edge captures the old word, as a real register behind the RAM would.
  assign store_src = store_cfg_q[logic_cell_pkg::SRC0_LSB +: 4];

  always_comb begin
    logic ce;
    logic sr;
    logic inv;
    logic din;
    logic act_edge;
    ce       = 1'b0;
    sr       = 1'b0;
    inv      = 1'b0;
    din      = 1'b0;
    act_edge = 1'b0;
    store_d  = store_q;
    for (int i = 0; i < 2; i++) begin
      ce  = cell_in.storage_clock_enable |
            store_cfg_q[logic_cell_pkg::CE_PERM_LSB + i];
      sr  = init_pulse_q |
            (cell_in.set_reset_input & store_cfg_q[logic_cell_pkg::SR_CONN_LSB + i]);
      inv = store_cfg_q[logic_cell_pkg::CLK_INV_LSB + i];
      din = pick_source(store_src[2*i +: 2], f_out, g_out, h_out,
                        cell_in.direct_in_zero);
      act_edge = inv ? fall_edge : rise_edge;
      if (sr) begin
        store_d[i] = store_cfg_q[logic_cell_pkg::SR_VALUE_LSB + i];
      end else if (store_cfg_q[logic_cell_pkg::LATCH_MODE_BIT]) begin
        if (ce && (cell_in.cell_clock == inv)) begin
          store_d[i] = din;
        end
      end else if (act_edge && ce) begin
        store_d[i] = din;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_q <= 2'h0;
    end else begin
      store_q <= store_d;
    end
  end

  assign cell_out = '{store_q:      store_q,
                      f_out:        f_out,
                      g_out:        g_out,
                      h_out:        h_out,
                      ram_read_out: ram_read_out};

endmodule // logic_cell

// ===== verif/logic_cell_assertions.sv
// Port-level assertions for the logic cell storage and RAM block.
`timescale 1ns/1ps
module logic_cell_assertions (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic [11:0]                  paddr,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic_cell_pkg::cell_in_type  cell_in,
  input wire logic_cell_pkg::cell_out_type cell_out
);
  logic [12:0] scfg_q, scfg_d;
  logic [2:0]  rcfg_q, rcfg_d;
  logic [1:0]  quiet_q, quiet_d;
  logic        calm, flop, ce0, sr0;

  // Config is mirrored from bus writes; cycles just after a write are skipped because the
  // init pulse and mode switches land with a latency this checker does not model.
  always_comb begin
    scfg_d  = scfg_q;
    rcfg_d  = rcfg_q;
    quiet_d = (quiet_q == 2'h0) ? 2'h0 : quiet_q - 2'h1;
    if (psel && penable && pwrite && pready) begin
      quiet_d = 2'h3;
      if (paddr == logic_cell_pkg::STORE_CFG_OFFSET) scfg_d = pwdata[12:0];
      if (paddr == logic_cell_pkg::RAM_CFG_OFFSET) rcfg_d = pwdata[2:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scfg_q  <= 13'h0000;
      rcfg_q  <= 3'h0;
      quiet_q <= 2'h3;
    end else begin
      scfg_q  <= scfg_d;
      rcfg_q  <= rcfg_d;
      quiet_q <= quiet_d;
    end
  end
  assign calm = (quiet_q == 2'h0);
  assign flop = calm && !scfg_q[0];
  assign ce0  = cell_in.storage_clock_enable | scfg_q[3];
  assign sr0  = cell_in.set_reset_input & scfg_q[7];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_edge0;
    cell_in.cell_clock != $past(cell_in.cell_clock) && cell_in.cell_clock != scfg_q[1];
  endsequence
  sequence s_wedge;
    cell_in.cell_clock != $past(cell_in.cell_clock) && cell_in.cell_clock != rcfg_q[2];
  endsequence
  sequence s_still;
    cell_in.cell_clock == $past(cell_in.cell_clock);
  endsequence

  AST_FLOP_LOAD: assert property ((flop && scfg_q[10:9] == 2'h3 && ce0 && !sr0) ##0 s_edge0
    |=> cell_out.store_q[0] == $past(cell_in.direct_in_zero)) else $error("flop missed data");
  AST_NO_EDGE_HOLD: assert property ((flop && !sr0) ##0 s_still
    |=> $stable(cell_out.store_q[0])) else $error("flop moved without edge");
  AST_ENABLE_LOW: assert property ((flop && !ce0 && !sr0) |=> $stable(cell_out.store_q[0]))
    else $error("flop moved while disabled");
  AST_SR_FORCE: assert property ((calm && sr0) |=> cell_out.store_q[0] == $past(scfg_q[5]))
    else $error("set/reset value not forced");
  AST_SR_UNCONNECTED: assert property ((flop && !scfg_q[8] && cell_in.set_reset_input)
    ##0 s_still |=> $stable(cell_out.store_q[1])) else $error("unconnected set/reset acted");
  AST_LATCH_PASS: assert property ((calm && scfg_q[0] && scfg_q[10:9] == 2'h3 && ce0
    && !sr0 && cell_in.cell_clock == scfg_q[1])
    |=> cell_out.store_q[0] == $past(cell_in.direct_in_zero))
    else $error("latch not transparent");
  AST_RAM_HOLD: assert property ((calm && rcfg_q[1:0] == 2'h1 && !cell_in.write_enable)
    ##1 (calm && $stable(cell_in.first_lut_inputs)) |-> $stable(cell_out.f_out))
    else $error("ram changed with write enable low");
  AST_RAM_WRITE: assert property ((calm && rcfg_q[1:0] == 2'h1 && cell_in.write_enable)
    ##0 s_wedge ##1 (calm && $stable(cell_in.first_lut_inputs))
    |-> cell_out.f_out == $past(cell_in.direct_in_zero)) else $error("ram write lost");
  AST_WIDE_OUT: assert property ((calm && rcfg_q[1:0] == 2'h3) |-> cell_out.h_out ==
    cell_out.ram_read_out && cell_out.ram_read_out ==
    (cell_in.direct_in_one ? cell_out.g_out : cell_out.f_out)) else $error("wide ram out wrong");
endmodule // logic_cell_assertions

// ===== verif/user_logic_model.sv
// Model of the user logic that drives the cell through the routing fabric.
`timescale 1ns/1ps
module user_logic_model (
  input  wire logic                   pclk,
  output logic_cell_pkg::cell_in_type cell_in
);
  initial cell_in = '0;

  // Every level is held two pclk cycles, so the write clock rests at least one full pclk cycle after its edge
  // and address, data and write enable are driven in the same assignment as the clock, so they can change with that edge.
  task automatic drive(input logic [5:0] ctl, input logic [7:0] adr);
    @(posedge pclk);
    cell_in <= logic_cell_pkg::cell_in_type'({ctl, adr});
    @(posedge pclk);
    @(negedge pclk);
  endtask
endmodule // user_logic_model

// ===== verif/testbench.sv
// Self-checking testbench for the logic cell storage and RAM block.
`timescale 1ns/1ps
module testbench;
  logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata, prdata, rd;
  logic_cell_pkg::cell_in_type  cell_in;
  logic_cell_pkg::cell_out_type cell_out;
  int                           n_errors, n_checks;

  always #25 pclk = ~pclk;

  logic_cell DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_in(cell_in), .cell_out(cell_out));
  user_logic_model partner (.pclk(pclk), .cell_in(cell_in));

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Drives one cell input level, then compares the masked cell outputs.
  task automatic step(input logic [5:0] ctl, input logic [7:0] adr, input logic [5:0] m, e);
    partner.drive(ctl, adr);
    check_data({26'h0, 6'(cell_out) & m}, {26'h0, e});
  endtask

  task automatic stop_test;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(2000 * 50);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // Test sequence; step control is {clk, ce, sr, we, d0, d1}, address {f, g}.
  // ----------------------------------------------------------------------
  initial begin
    pclk     = 1'h0;
    presetn  = 1'h0;
    psel     = 1'h0;
    penable  = 1'h0;
    pwrite   = 1'h0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, logic_cell_pkg::CELL_STAT_OFFSET, 32'h0);
    check_data(rd, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    check_data({rd[31:1], err}, 32'h1);
    apb(1'h1, logic_cell_pkg::STORE_CFG_OFFSET, 32'h1E04);
    step(6'h12, 8'h00, 6'h30, 6'h00);
    step(6'h32, 8'h00, 6'h30, 6'h10);
    step(6'h12, 8'h00, 6'h30, 6'h30);
    step(6'h00, 8'h00, 6'h30, 6'h30);
    step(6'h20, 8'h00, 6'h30, 6'h30);
    step(6'h10, 8'h00, 6'h30, 6'h10);
    apb(1'h1, logic_cell_pkg::STORE_CFG_OFFSET, 32'h1E18);
    step(6'h22, 8'h00, 6'h30, 6'h30);
    apb(1'h1, logic_cell_pkg::STORE_CFG_OFFSET, 32'h1E98);
    step(6'h2A, 8'h00, 6'h30, 6'h20);
    apb(1'h0, logic_cell_pkg::CELL_STAT_OFFSET, 32'h0);
    check_data(rd & 32'h30, 32'h20);
    step(6'h22, 8'h00, 6'h30, 6'h20);
    apb(1'h1, logic_cell_pkg::INIT_CTRL_OFFSET, 32'h1);
    step(6'h22, 8'h00, 6'h30, 6'h00);
    apb(1'h1, logic_cell_pkg::STORE_CFG_OFFSET, 32'h1E01);
    step(6'h12, 8'h00, 6'h30, 6'h30);
    step(6'h30, 8'h00, 6'h30, 6'h30);
    step(6'h10, 8'h00, 6'h30, 6'h00);
    apb(1'h1, logic_cell_pkg::RAM_CFG_OFFSET, 32'h1);
    step(6'h17, 8'h59, 6'h0C, 6'h00);
    step(6'h37, 8'h59, 6'h0C, 6'h0C);
    step(6'h10, 8'h59, 6'h0C, 6'h0C);
    step(6'h30, 8'h59, 6'h0C, 6'h0C);
    step(6'h10, 8'h69, 6'h0C, 6'h04);
    apb(1'h1, logic_cell_pkg::RAM_CFG_OFFSET, 32'h5);
    step(6'h36, 8'h69, 6'h0C, 6'h04);
    step(6'h16, 8'h69, 6'h0C, 6'h08);
    apb(1'h1, logic_cell_pkg::RAM_CFG_OFFSET, 32'h2);
    step(6'h12, 8'h30, 6'h08, 6'h00);
    step(6'h36, 8'h30, 6'h08, 6'h08);
    apb(1'h1, logic_cell_pkg::RAM_CFG_OFFSET, 32'h3);
    step(6'h17, 8'h30, 6'h03, 6'h00);
    step(6'h37, 8'h30, 6'h03, 6'h03);
    step(6'h30, 8'h30, 6'h03, 6'h03);
    // Lookup-fed flops: element 0 takes F, element 1 takes H (H table is F xor G).
    apb(1'h1, logic_cell_pkg::RAM_CFG_OFFSET, 32'h661);
    apb(1'h1, logic_cell_pkg::STORE_CFG_OFFSET, 32'h1140);
    step(6'h10, 8'h33, 6'h3F, 6'h3D);
    step(6'h30, 8'h33, 6'h3F, 6'h1D);
    step(6'h38, 8'h33, 6'h3F, 6'h3D);
    stop_test();
  end
endmodule // testbench

bind logic_cell logic_cell_assertions u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cell_in(cell_in), .cell_out(cell_out));
